// ---- art_pkg.sv ----
// Package of the converter result and trigger control block.
// Assumes one system clock with a synchronous reset and an APB slave port.
package art_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_RESULT_LOW  = 8'h78;
   localparam logic [7:0] IDX_RESULT_HIGH = 8'h79;
   localparam logic [7:0] IDX_CTRL_FIRST  = 8'h7A;
   localparam logic [7:0] IDX_CTRL_SECOND = 8'h7B;
   localparam logic [7:0] IDX_INPUT_SEL   = 8'h7C;
   localparam logic [7:0] IDX_PIN_OFF     = 8'h7E;
   localparam logic [7:0] IDX_PIN_VALUE   = 8'h7F;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_CONV_ON    = 7;
   localparam int BIT_START      = 6;
   localparam int BIT_AUTO_TRIG  = 5;
   localparam int BIT_DONE_FLAG  = 4;
   localparam int BIT_IRQ_EN     = 3;
   localparam int BIT_CMP_MUX    = 6;
   localparam int BIT_LEFT_ALIGN = 5;

   // Writable bits of the second control register
   localparam logic [7:0] CTRL_SECOND_MASK = 8'h47;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [9:0] RST_RESULT = 10'h000;
   localparam logic [6:0] RST_PRESC  = 7'h00;

   // Channel codes that select a differential pair
   localparam logic [4:0] DIFF_FIRST = 5'h08;
   localparam logic [4:0] DIFF_LAST  = 5'h1D;

   // Trigger source codes
   typedef enum logic [2:0] {
      ART_TRIG_FREE    = 3'h0,
      ART_TRIG_COMP    = 3'h1,
      ART_TRIG_EXT0    = 3'h2,
      ART_TRIG_T0_CMP  = 3'h3,
      ART_TRIG_T0_OVF  = 3'h4,
      ART_TRIG_T1_CMPB = 3'h5,
      ART_TRIG_T1_OVF  = 3'h6,
      ART_TRIG_T1_CAPT = 3'h7
   } art_trig_t;

   // Answer from the analog converter core
   typedef struct packed {
      logic       done;
      logic [9:0] data;
   } art_core_t;

   // Fields of the first control register
   typedef struct packed {
      logic       conv_on;
      logic       auto_trig;
      logic       irq_en;
      logic [2:0] div_sel;
   } art_ctrl_t;

endpackage

// ---- art_pin_sync.sv ----
// Three-stage synchroniser for the eight analog pins' digital values.
// Assumes asynchronous pin levels; a change counts once stages two and three agree.
`timescale 1ns/1ns
module art_pin_sync (
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic [7:0] pin_i,
   output logic      [7:0] pin_o
);

   logic [7:0] stage1;
   logic [7:0] stage2;
   logic [7:0] stage3;
   logic [7:0] next_pin;

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         next_pin[i] = (stage2[i] == stage3[i]) ? stage3[i] : pin_o[i];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         stage1 <= art_pkg::RST_BYTE;
         stage2 <= art_pkg::RST_BYTE;
         stage3 <= art_pkg::RST_BYTE;
         pin_o  <= art_pkg::RST_BYTE;
      end else begin
         stage1 <= pin_i;
         stage2 <= stage1;
         stage3 <= stage2;
         pin_o  <= next_pin;
      end
   end

endmodule

// ---- art_ctrl.sv ----
// Converter result and auto-trigger control with an APB register slave.
// Assumes an analog core that answers a start pulse with a one-cycle done and data,
// and trigger flags produced on the same clock.
//
// Behaviour
// - Converter clock is system clock divided by 2,2,4,8,16,32,64,128 per select.
// - Finished result goes to read-only low/high byte pair, reset zero.
// - Right aligned: bits 7:0 low, bits 9:8 in high bits 1:0.
// - Left aligned: bits 9:2 high, bits 1:0 in low bits 7:6.
// - Differential channel results are presented in two's complement.
// - Reading low byte locks the pair until the high byte is read.
// - Reserved bits 7 and 5:3 of second control read zero; write zero.
// - Trigger select is ignored while auto trigger is off.
// - Auto trigger starts a conversion on each rising edge of selected flag outside a running conversion.
// - Switching from a cleared to a set source is a rising edge.
// - Switching to free running never makes a trigger event.
// - Trigger codes: free, comparator, ext0, t0 cmp, t0 ovf, t1 cmpB, t1 ovf, t1 capt.
// - A set pin disable bit turns off that pin's digital buffer.
// - A set pin disable bit forces that pin's read value to zero.
// - Done flag sets when result registers update; it triggers free running.
// - Auto trigger enable bit allows starts on positive trigger edges.
// - Alignment changes show in the result bytes at once.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module art_ctrl (
   input  wire logic                SYS_CLK_I,
   input  wire logic                SRST_I,
   // APB slave
   input  wire logic                PSEL_I,
   input  wire logic                PENABLE_I,
   input  wire logic                PWRITE_I,
   input  wire logic [11:0]         PADDR_I,
   input  wire logic [31:0]         PWDATA_I,
   output logic      [31:0]         PRDATA_O,
   output logic                     PREADY_O,
   output logic                     PSLVERR_O,
   // Analog core
   input  wire art_pkg::art_core_t  CORE_I,
   output logic                     CONV_ON_O,
   output logic                     CONV_START_O,
   output logic                     CONV_CLK_O,
   output logic      [4:0]          CHANNEL_O,
   output logic      [1:0]          REF_SEL_O,
   output logic                     COMP_MUX_ON_O,
   // Trigger flags, index is the trigger code (bit 0 unused)
   input  wire logic [7:0]          TRIG_FLAGS_I,
   // Analog pins
   input  wire logic [7:0]          PIN_IN_I,
   output logic      [7:0]          PIN_BUF_OFF_O,
   output logic      [7:0]          PIN_VALUE_O
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic is_diff(input logic [4:0] ch);
      is_diff = (ch >= art_pkg::DIFF_FIRST) && (ch <= art_pkg::DIFF_LAST);
   endfunction

   function automatic logic trig_level(input logic [2:0] sel, input logic [7:0] flags, input logic done);
      trig_level = (sel == art_pkg::ART_TRIG_FREE) ? done : flags[sel];
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   art_pkg::art_ctrl_t ctrl;
   art_pkg::art_ctrl_t next_ctrl;
   logic [7:0]  ctrl_second;
   logic [7:0]  next_ctrl_second;
   logic [7:0]  input_sel;
   logic [7:0]  next_input_sel;
   logic [7:0]  pin_off;
   logic [7:0]  next_pin_off;
   logic        done_flag;
   logic        next_done_flag;
   logic        busy;
   logic        next_busy;
   logic        lock;
   logic        next_lock;
   logic [9:0]  result;
   logic [9:0]  next_result;
   logic [4:0]  active_ch;
   logic [4:0]  next_active_ch;
   logic        trig_prev;
   logic        next_trig_prev;
   logic [2:0]  sel_prev;
   logic [2:0]  next_sel_prev;
   logic        start;
   logic        next_start;
   logic [6:0]  presc;
   logic [6:0]  next_presc;
   logic        conv_clk;
   logic        next_conv_clk;
   logic [31:0] prdata;
   logic [31:0] next_prdata;
   logic        slverr;
   logic        next_slverr;

   logic [7:0]  pin_sync;
   logic [7:0]  idx;
   logic        addr_ok;
   logic        setup;
   logic        wr;
   logic        mapped;
   logic [7:0]  rd_byte;
   logic [7:0]  low_byte;
   logic [7:0]  high_byte;
   logic [9:0]  shown;
   logic        trig_now;
   logic        trig_edge;
   logic        lock_now;
   logic        sw_start;

   art_pin_sync u_pin_sync (
      .clk_i  (SYS_CLK_I),
      .srst_i (SRST_I),
      .pin_i  (PIN_IN_I),
      .pin_o  (pin_sync)
   );

   // ----------------------------------------------------------------
   // Address decode and read view
   // ----------------------------------------------------------------
   assign idx     = PADDR_I[9:2];
   assign addr_ok = (PADDR_I[11:10] == 2'h0) && (PADDR_I[1:0] == 2'h0);
   assign setup   = PSEL_I && !PENABLE_I;
   assign wr      = PSEL_I && PENABLE_I && PWRITE_I && addr_ok;

   always_comb begin
      shown = result;
      if (is_diff(active_ch)) begin
         shown = {~result[9], result[8:0]};
      end
      if (input_sel[art_pkg::BIT_LEFT_ALIGN]) begin
         high_byte = shown[9:2];
         low_byte  = {shown[1:0], 6'h00};
      end else begin
         high_byte = {6'h00, shown[9:8]};
         low_byte  = shown[7:0];
      end
   end

   always_comb begin
      mapped  = addr_ok;
      rd_byte = art_pkg::RST_BYTE;
      if (idx == art_pkg::IDX_RESULT_LOW) begin
         rd_byte = low_byte;
      end else if (idx == art_pkg::IDX_RESULT_HIGH) begin
         rd_byte = high_byte;
      end else if (idx == art_pkg::IDX_CTRL_FIRST) begin
         rd_byte = {ctrl.conv_on, busy, ctrl.auto_trig, done_flag, ctrl.irq_en, ctrl.div_sel};
      end else if (idx == art_pkg::IDX_CTRL_SECOND) begin
         rd_byte = ctrl_second & art_pkg::CTRL_SECOND_MASK;
      end else if (idx == art_pkg::IDX_INPUT_SEL) begin
         rd_byte = input_sel;
      end else if (idx == art_pkg::IDX_PIN_OFF) begin
         rd_byte = pin_off;
      end else if (idx == art_pkg::IDX_PIN_VALUE) begin
         rd_byte = PIN_VALUE_O;
      end else begin
         mapped = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Trigger detection
   // ----------------------------------------------------------------
   always_comb begin
      trig_now  = trig_level(ctrl_second[2:0], TRIG_FLAGS_I, done_flag);
      // Edge compares against the level of the previous selection as well
      trig_edge = trig_now && !trig_prev;
      if (ctrl_second[2:0] == art_pkg::ART_TRIG_FREE && sel_prev != art_pkg::ART_TRIG_FREE) begin
         trig_edge = 1'b0;
      end
      if (!ctrl.auto_trig) begin
         trig_edge = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_ctrl        = ctrl;
      next_ctrl_second = ctrl_second;
      next_input_sel   = input_sel;
      next_pin_off     = pin_off;
      next_done_flag   = done_flag;
      next_busy        = busy;
      next_lock        = lock;
      next_result      = result;
      next_active_ch   = active_ch;
      next_prdata      = prdata;
      next_slverr      = 1'b0;
      next_trig_prev   = trig_now;
      next_sel_prev    = ctrl_second[2:0];
      next_start       = 1'b0;
      sw_start         = 1'b0;

      // Read data is captured in the setup cycle
      if (setup) begin
         next_prdata = {24'h000000, rd_byte};
         next_slverr = !mapped;
         if (!PWRITE_I && addr_ok && idx == art_pkg::IDX_RESULT_LOW) begin
            next_lock = 1'b1;
         end else if (!PWRITE_I && addr_ok && idx == art_pkg::IDX_RESULT_HIGH) begin
            next_lock = 1'b0;
         end
      end
      lock_now = lock || (setup && !PWRITE_I && addr_ok && idx == art_pkg::IDX_RESULT_LOW);

      // Conversion completion
      if (CORE_I.done && busy) begin
         next_busy = 1'b0;
         if (!lock_now) begin
            next_result    = CORE_I.data;
            next_done_flag = 1'b1;
         end
      end

      // Register writes
      if (wr) begin
         if (idx == art_pkg::IDX_CTRL_FIRST) begin
            next_ctrl.conv_on   = PWDATA_I[art_pkg::BIT_CONV_ON];
            next_ctrl.auto_trig = PWDATA_I[art_pkg::BIT_AUTO_TRIG];
            next_ctrl.irq_en    = PWDATA_I[art_pkg::BIT_IRQ_EN];
            next_ctrl.div_sel   = PWDATA_I[2:0];
            sw_start            = PWDATA_I[art_pkg::BIT_START];
            // Write one clears; a completion in the same cycle wins
            if (PWDATA_I[art_pkg::BIT_DONE_FLAG] && !(CORE_I.done && busy && !lock_now)) begin
               next_done_flag = 1'b0;
            end
         end else if (idx == art_pkg::IDX_CTRL_SECOND) begin
            next_ctrl_second = PWDATA_I[7:0] & art_pkg::CTRL_SECOND_MASK;
         end else if (idx == art_pkg::IDX_INPUT_SEL) begin
            next_input_sel = PWDATA_I[7:0];
         end else if (idx == art_pkg::IDX_PIN_OFF) begin
            next_pin_off = PWDATA_I[7:0];
         end
      end

      // Start of a conversion
      if (next_ctrl.conv_on && !next_busy && (sw_start || trig_edge)) begin
         next_start     = 1'b1;
         next_busy      = 1'b1;
         next_active_ch = next_input_sel[4:0];
      end
      // Turning the converter off ends any conversion
      if (!next_ctrl.conv_on) begin
         next_busy = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   always_comb begin
      next_presc    = art_pkg::RST_PRESC;
      next_conv_clk = 1'b0;
      if (ctrl.conv_on) begin
         next_presc = presc + 7'h01;
         if (ctrl.div_sel == 3'h0) begin
            next_conv_clk = next_presc[0];
         end else begin
            next_conv_clk = next_presc[ctrl.div_sel - 3'h1];
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge SYS_CLK_I) begin
      if (SRST_I) begin
         ctrl        <= '0;
         ctrl_second <= art_pkg::RST_BYTE;
         input_sel   <= art_pkg::RST_BYTE;
         pin_off     <= art_pkg::RST_BYTE;
         done_flag   <= 1'b0;
         busy        <= 1'b0;
         lock        <= 1'b0;
         result      <= art_pkg::RST_RESULT;
         active_ch   <= 5'h00;
         trig_prev   <= 1'b0;
         sel_prev    <= 3'h0;
         start       <= 1'b0;
         presc       <= art_pkg::RST_PRESC;
         conv_clk    <= 1'b0;
         prdata      <= 32'h00000000;
         slverr      <= 1'b0;
      end else begin
         ctrl        <= next_ctrl;
         ctrl_second <= next_ctrl_second;
         input_sel   <= next_input_sel;
         pin_off     <= next_pin_off;
         done_flag   <= next_done_flag;
         busy        <= next_busy;
         lock        <= next_lock;
         result      <= next_result;
         active_ch   <= next_active_ch;
         trig_prev   <= next_trig_prev;
         sel_prev    <= next_sel_prev;
         start       <= next_start;
         presc       <= next_presc;
         conv_clk    <= next_conv_clk;
         prdata      <= next_prdata;
         slverr      <= next_slverr;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign PRDATA_O      = prdata;
   assign PREADY_O      = PSEL_I && PENABLE_I;
   assign PSLVERR_O     = PSEL_I && PENABLE_I && slverr;
   assign CONV_ON_O     = ctrl.conv_on;
   assign CONV_START_O  = start;
   assign CONV_CLK_O    = conv_clk;
   assign CHANNEL_O     = input_sel[4:0];
   assign REF_SEL_O     = input_sel[7:6];
   assign COMP_MUX_ON_O = ctrl_second[art_pkg::BIT_CMP_MUX];
   assign PIN_BUF_OFF_O = pin_off;
   assign PIN_VALUE_O   = pin_sync & ~pin_off;

endmodule

// ---- art_core_model.sv ----
// Behavioural analog core: answers each start with one done pulse after a set delay.
// Assumes start and enable come from the control block on the same clock.
`timescale 1ns/1ns
module art_core_model (
   input  wire logic          clk_i,
   input  wire logic          srst_i,
   input  wire logic          start_i,
   input  wire logic          on_i,
   input  wire logic [7:0]    delay_i,
   input  wire logic [9:0]    value_i,
   output art_pkg::art_core_t core_o
);
   int cnt = 0;
   initial core_o = '0;
   always @(posedge clk_i) begin
      core_o.done <= 1'b0;
      // Data is only valid with done, so it keeps changing
      core_o.data <= ~core_o.data;
      if (srst_i || !on_i) begin
         cnt <= 0;
      end else if (start_i) begin
         cnt <= delay_i + 1;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
      if (cnt == 1 && on_i && !srst_i) begin
         core_o.done <= 1'b1;
         core_o.data <= value_i;
      end
   end
endmodule

// ---- art_ctrl_chk.sv ----
// Port checker of the converter control block.
// Assumes one clock, synchronous active-high reset, APB zero wait states.
`timescale 1ns/1ns
module art_ctrl_chk (
   input wire logic        SYS_CLK_I,
   input wire logic        SRST_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        CONV_ON_O,
   input wire logic        CONV_START_O,
   input wire logic        CONV_CLK_O,
   input wire logic [7:0]  PIN_BUF_OFF_O,
   input wire logic [7:0]  PIN_VALUE_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (SRST_I);
   logic acc;
   logic rd;
   logic left_align;
   logic next_left_align;
   assign acc = PSEL_I && PENABLE_I;
   assign rd = acc && !PWRITE_I;
   // Alignment bit as last written
   always_comb begin
      next_left_align = SRST_I ? 1'b0 : ((acc && PWRITE_I && PADDR_I == 12'h1F0) ? PWDATA_I[5] : left_align);
   end
   always_ff @(posedge SYS_CLK_I) begin
      left_align <= next_left_align;
   end
   clk_off_a: assert property (
      !CONV_ON_O && !$past(CONV_ON_O) |-> !CONV_CLK_O) else $error("Converter clock while off");
   start_pulse_a: assert property (
      CONV_START_O |=> !CONV_START_O) else $error("Start longer than one cycle");
   start_on_a: assert property (
      CONV_START_O |-> CONV_ON_O) else $error("Start while converter off");
   reserved_zero_a: assert property (
      rd && PADDR_I == 12'h1EC |-> (PRDATA_O & 32'h000000B8) == 32'h0) else $error("Reserved bits set");
   pin_load_a: assert property (
      acc && PWRITE_I && PADDR_I == 12'h1F8 |=> PIN_BUF_OFF_O == $past(PWDATA_I[7:0]))
      else $error("Pin disable not loaded");
   pin_mask_a: assert property (
      $stable(PIN_BUF_OFF_O) |-> (PIN_VALUE_O & PIN_BUF_OFF_O) == 8'h00) else $error("Disabled pin reads one");
   right_high_a: assert property (
      rd && PADDR_I == 12'h1E4 && !left_align |-> PRDATA_O[7:2] == 6'h00) else $error("High byte bits set");
   left_low_a: assert property (
      rd && PADDR_I == 12'h1E0 && left_align |-> PRDATA_O[5:0] == 6'h00) else $error("Low byte bits set");
endmodule

bind art_ctrl art_ctrl_chk i_art_ctrl_chk (.*);

// ---- art_ctrl_test.sv ----
// Self-checking bench of the converter control block.
// Assumes the core model answers starts; flags and pins are driven here.
`timescale 1ns/1ns
module art_ctrl_test;
   logic               clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]        paddr = 12'h000;
   logic [31:0]        pwdata = 32'h0, prdata, rdv;
   logic               pready, pslverr, conv_on, conv_start, conv_clk, la, cmux;
   art_pkg::art_core_t core;
   logic [7:0]         trig = 8'h00, pins = 8'h00, core_delay = 8'h04, buf_off, pin_val, p, m;
   logic [9:0]         core_value = 10'h000, d, e;
   logic [4:0]         ch, ch_o;
   logic [1:0]         r, ref_o;
   int                 err_total = 0, samples_checked = 0, cyc = 0, starts = 0, n, t0;

   always #2 clk = ~clk;

   art_ctrl i_art_ctrl (
      .SYS_CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .CORE_I(core), .CONV_ON_O(conv_on), .CONV_START_O(conv_start), .CONV_CLK_O(conv_clk),
      .CHANNEL_O(ch_o), .REF_SEL_O(ref_o), .COMP_MUX_ON_O(cmux), .TRIG_FLAGS_I(trig), .PIN_IN_I(pins),
      .PIN_BUF_OFF_O(buf_off), .PIN_VALUE_O(pin_val));
   art_core_model i_art_core_model (.clk_i(clk), .srst_i(srst), .start_i(conv_start), .on_i(conv_on),
      .delay_i(core_delay), .value_i(core_value), .core_o(core));

   always @(posedge clk) begin
      cyc++;
      if (conv_start === 1'b1) begin
         starts++;
      end
      if (cyc == 30000) begin
         err_total++;
         test_done();
      end
   end

   task automatic test_done();
      $display("Checks: %0d, mismatches: %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // APB transfer; read data and error taken at the ready edge
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdv = {prdata[31:1], prdata[0]};
      t0 = (pslverr === 1'b1) ? 1 : 0;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic chk(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      cmp(rdv, {24'h000000, exp});
   endtask

   task automatic wait_done();
      do apb(1'b0, 8'h7A, 8'h00); while (rdv[4] !== 1'b1);
   endtask

   task automatic pulse(input int c);
      trig[c] <= 1'b1;
      repeat (3) @(posedge clk);
      trig[c] <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   initial begin
      void'($urandom(32'hFDC23BC0));
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      for (int k = 8'h78; k < 8'h80; k++) if (k != 8'h7D) chk(8'(k), 8'h00);
      apb(1'b0, 8'h7D, 8'h00);
      cmp(t0, 1);
      apb(1'b1, 8'h7B, 8'h47);
      chk(8'h7B, 8'h47);
      cmp({31'h0, cmux}, 32'h1);
      for (int s = 0; s < 8; s++) begin
         apb(1'b1, 8'h7A, 8'h80 | 8'(s));
         @(posedge conv_clk);
         n = cyc;
         @(posedge conv_clk);
         cmp(cyc - n, (s < 2) ? 2 : (1 << s));
         apb(1'b1, 8'h7A, 8'h00);
      end
      // Conversions, both alignments, flipped between the two reads
      for (int i = 0; i < 6; i++) begin
         d = 10'($urandom);
         ch = 5'($urandom);
         r = 2'($urandom);
         la = 1'(i);
         core_value <= d;
         core_delay <= 8'($urandom_range(20, 1));
         apb(1'b1, 8'h7C, {r, la, ch});
         cmp({25'h0, ref_o, ch_o}, {25'h0, r, ch});
         apb(1'b1, 8'h7A, 8'hC0);
         wait_done();
         e = (ch >= art_pkg::DIFF_FIRST && ch <= art_pkg::DIFF_LAST) ? d ^ 10'h200 : d;
         chk(8'h78, la ? {e[1:0], 6'h00} : e[7:0]);
         apb(1'b1, 8'h7C, {r, ~la, ch});
         chk(8'h79, la ? {6'h00, e[9:8]} : e[9:2]);
         apb(1'b1, 8'h7A, 8'h90);
      end
      // Result arriving while the pair is locked
      d = 10'($urandom);
      core_value <= d;
      apb(1'b1, 8'h7C, 8'h00);
      apb(1'b1, 8'h7A, 8'hC0);
      wait_done();
      apb(1'b1, 8'h7A, 8'h90);
      chk(8'h78, d[7:0]);
      core_value <= ~d;
      apb(1'b1, 8'h7A, 8'hC0);
      repeat (30) @(posedge clk);
      chk(8'h7A, 8'h80);
      chk(8'h79, {6'h00, d[9:8]});
      chk(8'h78, d[7:0]);
      chk(8'h79, {6'h00, d[9:8]});
      for (int c = 1; c < 8; c++) begin
         apb(1'b1, 8'h7B, 8'(c));
         n = starts;
         pulse(c);
         cmp(starts - n, 0);
         apb(1'b1, 8'h7A, 8'hA0);
         pulse(c % 7 + 1);
         cmp(starts - n, 0);
         pulse(c);
         wait_done();
         cmp(starts - n, 1);
         apb(1'b1, 8'h7A, 8'h90);
      end
      apb(1'b1, 8'h7B, 8'h01);
      trig <= 8'h04;
      apb(1'b1, 8'h7A, 8'hA0);
      n = starts;
      apb(1'b1, 8'h7B, 8'h02);
      wait_done();
      cmp(starts - n, 1);
      trig <= 8'h00;
      apb(1'b1, 8'h7B, 8'h00);
      repeat (30) @(posedge clk);
      cmp(starts - n, 1);
      apb(1'b1, 8'h7A, 8'hB0);
      n = starts;
      apb(1'b1, 8'h7A, 8'hE0);
      wait_done();
      repeat (30) @(posedge clk);
      cmp(starts - n, 2);
      apb(1'b1, 8'h7A, 8'h00);
      for (int i = 0; i < 4; i++) begin
         p = 8'($urandom);
         m = 8'($urandom);
         pins <= p;
         apb(1'b1, 8'h7E, m);
         repeat (6) @(posedge clk);
         cmp({24'h0, buf_off}, {24'h0, m});
         cmp({24'h0, pin_val}, {24'h0, p & ~m});
         chk(8'h7F, p & ~m);
      end
      test_done();
   end
endmodule
